// ---- logic/lcd_serial_port.sv ----
// Serial receive port of a segment LCD driver: 4-line, 3-line and two-wire links
//
// How it works
// - Select 0/1 runs 4-line mode; control line high at 8th rise means data.
// - Control line low at 8th rise in 4-line mode marks the byte as a command.
// - Select 1/0 runs 3-line mode; first bit is data/command flag, eight bits follow.
// - Chip select rising mid-byte drops the partial byte; host resends it whole.
// - Chip select high clears the bit counter and shift register.
// - Both select pins low makes the port a write-only two-wire bus slave.
// - One bit per clock pulse; data changing while clock is high is a condition.
// - Data falling while clock is high is a START and opens a transaction.
// - Data rising while clock is high is a STOP and ends the transaction.
// - Addressed slave pulls data low through the whole ninth clock high phase.
// - Only slave address 0111110 after a START is answered.
// - A mismatched address gets no acknowledge and the rest is ignored.
// - Every control and data byte received while addressed is acknowledged.
// - Continuation flag clear: all bytes up to STOP or restart are data.
// - Continuation flag set: one data byte, then another control byte.
// - Control flag 1: bytes go to display RAM, pointer advances after each.
// - Control flag 0: bytes are passed to the instruction decoder.
// - Direction bit must be write; reads are never supported.
// - SPI modes sample the data line on each rising write clock edge.
// - Chip select high disables and reinitialises the SPI receiver.
`timescale 1ns/1ps
module lcd_serial_port (
   // Clock, reset, enable
   input  wire logic                          clk_sys_in,
   input  wire logic                          resetn_in,
   input  wire logic                          clk_en_in,
   // Link pins
   input  wire logic                          chip_select_bar_in,
   input  wire logic                          write_clock_in,
   input  wire logic                          data_in,
   input  wire logic                          data_command_select_in,
   input  wire logic                          interface_select_lo_in,
   input  wire logic                          interface_select_hi_in,
   output logic                               data_out,
   output logic                               data_oe_out,
   // Display RAM write side
   input  wire logic                          ptr_load_in,
   input  wire logic [lcd_port_pkg::PTR_W-1:0] ptr_value_in,
   output logic                               ram_wr_out,
   output logic      [lcd_port_pkg::PTR_W-1:0] ram_addr_out,
   output logic      [7:0]                    ram_data_out,
   // Instruction decoder side
   output logic                               cmd_valid_out,
   output logic      [7:0]                    cmd_byte_out,
   // Status
   output logic                               addressed_out,
   output logic                               discard_out
);

   logic [lcd_port_pkg::SYNC_W-1:0] sync_s;
   logic                            csb_s;
   logic                            clk_s;
   logic                            sda_s;
   logic                            dc_s;
   logic [1:0]                      mode_s;
   logic                            clk_prev_q;
   logic                            sda_prev_q;
   logic                            csb_prev_q;
   logic                            clk_rise;
   logic                            clk_fall;
   logic                            start_det;
   logic                            stop_det;
   logic                            spi_mode;
   logic [3:0]                      spi_last;
   logic [3:0]                      spi_cnt_q;
   logic [7:0]                      spi_sh_q;
   logic                            spi_flag_q;
   logic                            spi_done;
   logic [7:0]                      spi_byte;
   logic                            spi_kind;
   lcd_port_pkg::iic_state_t        state_q;
   logic [3:0]                      bit_cnt_q;
   logic [7:0]                      iic_sh_q;
   logic                            ack_phase_q;
   logic                            ack_q;
   logic                            dc_q;
   logic                            byte_end;
   logic                            iic_emit;
   logic                            ev_valid;
   logic [7:0]                      ev_byte;
   logic                            ev_kind;
   logic [lcd_port_pkg::PTR_W-1:0]  ptr_q;

   // Address byte accepted only for our address with write direction
   function automatic logic addr_match(input logic [7:0] b);
      addr_match = (b[7:1] == lcd_port_pkg::SLAVE_ADDR) && (b[0] == lcd_port_pkg::WRITE_DIR);
   endfunction

   // Every pin is synchronised before any logic reads it
   pin_sync #(
      .W         (lcd_port_pkg::SYNC_W),
      .RESET_VAL (lcd_port_pkg::SYNC_RESET)
   ) u_sync (
      .clk_sys_in (clk_sys_in),
      .resetn_in  (resetn_in),
      .clk_en_in  (clk_en_in),
      .pins_in    ({interface_select_hi_in, interface_select_lo_in,
                    data_command_select_in, data_in, write_clock_in,
                    chip_select_bar_in}),
      .sync_out   (sync_s)
   );

   assign csb_s  = sync_s[lcd_port_pkg::S_CSB];
   assign clk_s  = sync_s[lcd_port_pkg::S_CLK];
   assign sda_s  = sync_s[lcd_port_pkg::S_DATA];
   assign dc_s   = sync_s[lcd_port_pkg::S_DC];
   assign mode_s = {sync_s[lcd_port_pkg::S_IF_HI], sync_s[lcd_port_pkg::S_IF_LO]};

   // Previous levels for edge and condition detection
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         clk_prev_q <= 1'h1;
         sda_prev_q <= 1'h1;
         csb_prev_q <= 1'h1;
      end else if (clk_en_in) begin
         clk_prev_q <= clk_s;
         sda_prev_q <= sda_s;
         csb_prev_q <= csb_s;
      end
   end

   // Edges of the link clock and bus conditions while the clock stays high
   assign clk_rise  = clk_s & ~clk_prev_q;
   assign clk_fall  = ~clk_s & clk_prev_q;
   assign start_det = clk_s & clk_prev_q & sda_prev_q & ~sda_s;
   assign stop_det  = clk_s & clk_prev_q & ~sda_prev_q & sda_s;

   // SPI mode decode and length of one frame
   assign spi_mode = (mode_s == lcd_port_pkg::MODE_SPI4) || (mode_s == lcd_port_pkg::MODE_SPI3);
   assign spi_last = (mode_s == lcd_port_pkg::MODE_SPI3) ? lcd_port_pkg::SPI3_LAST
                                                         : lcd_port_pkg::SPI4_LAST;

   // SPI shifter: cleared by chip select, sampled on rising write clock
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         spi_cnt_q  <= 4'h0;
         spi_sh_q   <= 8'h00;
         spi_flag_q <= 1'h0;
      end else if (clk_en_in) begin
         if (!spi_mode || csb_s) begin
            spi_cnt_q  <= 4'h0;
            spi_sh_q   <= 8'h00;
            spi_flag_q <= 1'h0;
         end else if (clk_rise) begin
            if (mode_s == lcd_port_pkg::MODE_SPI3 && spi_cnt_q == 4'h0) begin
               spi_flag_q <= sda_s;
               spi_cnt_q  <= 4'h1;
            end else begin
               spi_sh_q <= {spi_sh_q[6:0], sda_s};
               if (spi_cnt_q == spi_last) begin
                  spi_cnt_q <= 4'h0;
               end else begin
                  spi_cnt_q <= spi_cnt_q + 4'h1;
               end
            end
         end
      end
   end

   // A complete SPI byte; the 4-line tag is the control line at the 8th rise
   assign spi_done = spi_mode & ~csb_s & clk_rise & (spi_cnt_q == spi_last);
   assign spi_byte = {spi_sh_q[6:0], sda_s};
   assign spi_kind = (mode_s == lcd_port_pkg::MODE_SPI4) ? dc_s : spi_flag_q;

   // Partial SPI byte abandoned by chip select
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         discard_out <= 1'h0;
      end else if (clk_en_in) begin
         discard_out <= spi_mode & csb_s & ~csb_prev_q & (spi_cnt_q != 4'h0);
      end
   end

   // Two-wire byte boundary: falling clock after eight bits
   assign byte_end = clk_fall & ~ack_phase_q & (bit_cnt_q == lcd_port_pkg::BYTE_BITS);
   assign iic_emit = byte_end & ((state_q == lcd_port_pkg::I_ONE) ||
                                 (state_q == lcd_port_pkg::I_STREAM));

   // Two-wire receiver: conditions, bit shifting and byte sequencing
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         state_q     <= lcd_port_pkg::I_IDLE;
         bit_cnt_q   <= 4'h0;
         iic_sh_q    <= 8'h00;
         ack_phase_q <= 1'h0;
         ack_q       <= 1'h0;
         dc_q        <= 1'h0;
      end else if (clk_en_in) begin
         if (mode_s != lcd_port_pkg::MODE_IIC) begin
            state_q     <= lcd_port_pkg::I_IDLE;
            bit_cnt_q   <= 4'h0;
            ack_phase_q <= 1'h0;
            ack_q       <= 1'h0;
         end else if (start_det) begin
            state_q     <= lcd_port_pkg::I_ADDR;
            bit_cnt_q   <= 4'h0;
            ack_phase_q <= 1'h0;
            ack_q       <= 1'h0;
         end else if (stop_det) begin
            state_q     <= lcd_port_pkg::I_IDLE;
            bit_cnt_q   <= 4'h0;
            ack_phase_q <= 1'h0;
            ack_q       <= 1'h0;
         end else if (state_q == lcd_port_pkg::I_IDLE) begin
            bit_cnt_q <= 4'h0;
         end else if (clk_rise && !ack_phase_q && bit_cnt_q != lcd_port_pkg::BYTE_BITS) begin
            iic_sh_q  <= {iic_sh_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end else if (clk_fall && ack_phase_q) begin
            ack_phase_q <= 1'h0;
            ack_q       <= 1'h0;
         end else if (byte_end) begin
            ack_phase_q <= 1'h1;
            bit_cnt_q   <= 4'h0;
            case (state_q)
               lcd_port_pkg::I_ADDR: begin
                  if (addr_match(iic_sh_q)) begin
                     ack_q   <= 1'h1;
                     state_q <= lcd_port_pkg::I_CTRL;
                  end else begin
                     state_q <= lcd_port_pkg::I_SKIP;
                  end
               end
               lcd_port_pkg::I_CTRL: begin
                  ack_q <= 1'h1;
                  dc_q  <= iic_sh_q[lcd_port_pkg::DC_BIT];
                  if (iic_sh_q[lcd_port_pkg::CONT_BIT]) begin
                     state_q <= lcd_port_pkg::I_ONE;
                  end else begin
                     state_q <= lcd_port_pkg::I_STREAM;
                  end
               end
               lcd_port_pkg::I_ONE: begin
                  ack_q   <= 1'h1;
                  state_q <= lcd_port_pkg::I_CTRL;
               end
               lcd_port_pkg::I_STREAM: begin
                  ack_q <= 1'h1;
               end
               default: begin
                  ack_q <= 1'h0;
               end
            endcase
         end
      end
   end

   // Open-drain data pin: only ever pulls low, enable high while acknowledging
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         data_out    <= 1'h0;
         data_oe_out <= 1'h0;
      end else if (clk_en_in) begin
         data_out    <= 1'h0;
         data_oe_out <= ack_q;
      end
   end

   // Merge byte events from both receivers
   assign ev_valid = spi_done | iic_emit;
   assign ev_byte  = spi_done ? spi_byte : iic_sh_q;
   assign ev_kind  = spi_done ? spi_kind : dc_q;

   // Display RAM pointer: a load from the decoder wins over auto increment
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         ptr_q <= lcd_port_pkg::PTR_RESET;
      end else if (clk_en_in) begin
         if (ptr_load_in) begin
            ptr_q <= ptr_value_in;
         end else if (ev_valid && ev_kind) begin
            ptr_q <= ptr_q + 6'h01;
         end
      end
   end

   // Byte delivery to display RAM or instruction decoder
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         ram_wr_out    <= 1'h0;
         ram_addr_out  <= lcd_port_pkg::PTR_RESET;
         ram_data_out  <= 8'h00;
         cmd_valid_out <= 1'h0;
         cmd_byte_out  <= 8'h00;
      end else if (clk_en_in) begin
         ram_wr_out    <= ev_valid & ev_kind;
         cmd_valid_out <= ev_valid & ~ev_kind;
         if (ev_valid && ev_kind) begin
            ram_addr_out <= ptr_q;
            ram_data_out <= ev_byte;
         end
         if (ev_valid && !ev_kind) begin
            cmd_byte_out <= ev_byte;
         end
      end
   end

   // Addressed status of the two-wire slave
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         addressed_out <= 1'h0;
      end else if (clk_en_in) begin
         addressed_out <= (state_q == lcd_port_pkg::I_CTRL) ||
                          (state_q == lcd_port_pkg::I_ONE) ||
                          (state_q == lcd_port_pkg::I_STREAM);
      end
   end

   // Checks on the receive behaviour
   property p_csb_clear;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (spi_mode && csb_s) |=> (spi_cnt_q == 4'h0 && spi_sh_q == 8'h00);
   endproperty
   a_csb_clear: assert property (p_csb_clear) else $error("SPI state not cleared");

   property p_discard;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (spi_mode && csb_s && !csb_prev_q && spi_cnt_q != 4'h0) |=> discard_out && !ram_wr_out;
   endproperty
   a_discard: assert property (p_discard) else $error("Partial byte not dropped");

   property p_spi4_kind;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (spi_done && mode_s == lcd_port_pkg::MODE_SPI4) |=> (ram_wr_out == $past(dc_s));
   endproperty
   a_spi4_kind: assert property (p_spi4_kind) else $error("4-line tag wrong");

   property p_spi3_kind;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (spi_done && mode_s == lcd_port_pkg::MODE_SPI3) |=> (cmd_valid_out == !$past(spi_flag_q));
   endproperty
   a_spi3_kind: assert property (p_spi3_kind) else $error("3-line tag wrong");

   property p_start;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (mode_s == lcd_port_pkg::MODE_IIC && start_det) |=> state_q == lcd_port_pkg::I_ADDR;
   endproperty
   a_start: assert property (p_start) else $error("START not seen");

   property p_stop;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (mode_s == lcd_port_pkg::MODE_IIC && stop_det && !start_det)
         |=> state_q == lcd_port_pkg::I_IDLE ##1 !addressed_out;
   endproperty
   a_stop: assert property (p_stop) else $error("STOP not seen");

   property p_nack;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (byte_end && state_q == lcd_port_pkg::I_ADDR && !addr_match(iic_sh_q))
         |=> !ack_q ##1 !data_oe_out;
   endproperty
   a_nack: assert property (p_nack) else $error("Foreign address acknowledged");

   property p_ack;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (byte_end && !start_det && !stop_det && mode_s == lcd_port_pkg::MODE_IIC &&
       state_q == lcd_port_pkg::I_ADDR && addr_match(iic_sh_q)) |=> ##1 data_oe_out;
   endproperty
   a_ack: assert property (p_ack) else $error("Own address not acknowledged");

   property p_oe_iic;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      ack_q |-> mode_s == lcd_port_pkg::MODE_IIC || $past(mode_s) == lcd_port_pkg::MODE_IIC;
   endproperty
   a_oe_iic: assert property (p_oe_iic) else $error("Pin driven outside two-wire mode");

   property p_ptr_inc;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (ram_wr_out && !$past(ptr_load_in)) |-> ptr_q == ram_addr_out + 6'h01;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("Pointer did not advance");

   property p_one_data;
      @(posedge clk_sys_in) disable iff (!resetn_in || !clk_en_in)
      (iic_emit && state_q == lcd_port_pkg::I_ONE && !start_det && !stop_det)
         |=> state_q == lcd_port_pkg::I_CTRL;
   endproperty
   a_one_data: assert property (p_one_data) else $error("Control byte not expected");

   // Main scenarios
   c_spi4_data: cover property (@(posedge clk_sys_in) ram_wr_out && mode_s == 2'h2);
   c_spi3_cmd: cover property (@(posedge clk_sys_in) cmd_valid_out && mode_s == 2'h1);
   c_iic_stream: cover property (@(posedge clk_sys_in)
      state_q == lcd_port_pkg::I_STREAM && ram_wr_out);
   c_iic_skip: cover property (@(posedge clk_sys_in) state_q == lcd_port_pkg::I_SKIP);

endmodule // lcd_serial_port

// ---- pkg/lcd_port_pkg.sv ----
// Constants and types shared by the LCD driver serial receive port
package lcd_port_pkg;

   // Interface select codes, written as {interface_select_hi, interface_select_lo}
   localparam logic [1:0] MODE_IIC   = 2'h0;
   localparam logic [1:0] MODE_SPI3  = 2'h1;
   localparam logic [1:0] MODE_SPI4  = 2'h2;
   localparam logic [1:0] MODE_TYPEB = 2'h3;

   // Two-wire slave address and control byte fields
   localparam logic [6:0] SLAVE_ADDR  = 7'h3E;
   localparam int         CONT_BIT    = 7;
   localparam int         DC_BIT      = 6;
   localparam logic       WRITE_DIR   = 1'h0;

   // Bit counts
   localparam logic [3:0] BYTE_BITS   = 4'h8;
   localparam logic [3:0] SPI4_LAST   = 4'h7;
   localparam logic [3:0] SPI3_LAST   = 4'h8;

   // Display RAM pointer
   localparam int         PTR_W       = 6;
   localparam logic [5:0] PTR_RESET   = 6'h00;

   // Pin synchroniser layout and idle levels
   localparam int         SYNC_W      = 6;
   localparam logic [5:0] SYNC_RESET  = 6'h3F;
   localparam int         S_CSB       = 0;
   localparam int         S_CLK       = 1;
   localparam int         S_DATA      = 2;
   localparam int         S_DC        = 3;
   localparam int         S_IF_LO     = 4;
   localparam int         S_IF_HI     = 5;

   // Two-wire receiver states
   typedef enum logic [2:0] {
      I_IDLE,
      I_ADDR,
      I_CTRL,
      I_ONE,
      I_STREAM,
      I_SKIP
   } iic_state_t;

endpackage

// ---- logic/pin_sync.sv ----
// Two-flop synchroniser bank for the asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
   parameter int         W         = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // Clock, reset, enable
   input  wire logic         clk_sys_in,
   input  wire logic         resetn_in,
   input  wire logic         clk_en_in,
   // Pins and synchronised levels
   input  wire logic [W-1:0] pins_in,
   output logic      [W-1:0] sync_out
);

   genvar g;

   // One two-stage chain per pin; only the second stage is visible
   generate
      for (g = 0; g < W; g = g + 1) begin : g_chain
         logic meta_q;
         logic stab_q;
         always_ff @(posedge clk_sys_in) begin
            if (!resetn_in) begin
               meta_q <= RESET_VAL[g];
               stab_q <= RESET_VAL[g];
            end else if (clk_en_in) begin
               meta_q <= pins_in[g];
               stab_q <= meta_q;
            end
         end
         assign sync_out[g] = stab_q;
      end
   endgenerate

endmodule // pin_sync

// ---- sim/host_link_model.sv ----
// Host serial master model that drives the LCD port link pins
`timescale 1ns/1ps
module host_link_model (
   // Clock and sensed data line
   input  wire logic clk_sys_in,
   input  wire logic data_line_in,
   // Link pins
   output logic      chip_select_bar_out,
   output logic      write_clock_out,
   output logic      data_out,
   output logic      data_command_select_out
);
   // Idle link: deselected, clock parked high, data released high
   initial begin
      chip_select_bar_out = 1'h1;
      write_clock_out = 1'h1;
      data_out = 1'h1;
      data_command_select_out = 1'h0;
   end

   // Pin changes land on falling system clock edges
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   // SPI frame of n bits, MSB first; fewer bits than the frame aborts it
   task automatic spi_frame(input logic [8:0] v, input int n, input logic dc);
      chip_select_bar_out = 1'h0;
      data_command_select_out = dc;
      tick(4);
      for (int i = n - 1; i >= 0; i--) begin
         write_clock_out = 1'h0;
         data_out = v[i];
         tick(4);
         write_clock_out = 1'h1;
         tick(4);
      end
      chip_select_bar_out = 1'h1;
      data_out = ~data_out;
      tick(8);
   endtask

   // START from an idle bus
   task automatic i2c_start();
      data_out = 1'h1;
      tick(4);
      data_out = 1'h0;
      tick(4);
      write_clock_out = 1'h0;
   endtask

   // One bit; data moves mid low phase only, so ACK release has settled
   task automatic i2c_bit(input logic b);
      tick(6);
      data_out = b;
      tick(2);
      write_clock_out = 1'h1;
      tick(4);
      write_clock_out = 1'h0;
   endtask

   // Byte plus ACK slot; ack is set only if the line stayed low in the high phase
   task automatic i2c_byte(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         i2c_bit(v[i]);
      end
      tick(6);
      data_out = 1'h1;
      tick(2);
      write_clock_out = 1'h1;
      tick(1);
      ack = ~data_line_in;
      tick(2);
      ack = ack & ~data_line_in;
      tick(1);
      write_clock_out = 1'h0;
   endtask

   // STOP ends the transfer
   task automatic i2c_stop();
      tick(6);
      data_out = 1'h0;
      tick(2);
      write_clock_out = 1'h1;
      tick(4);
      data_out = 1'h1;
      tick(8);
   endtask
endmodule // host_link_model

// ---- sim/lcd_serial_port_tb_top.sv ----
// Testbench for the LCD driver serial receive port
`timescale 1ns/1ps
module lcd_serial_port_tb_top;
   logic        clk_sys_in, resetn_in, if_lo, if_hi, ptr_load, chip_select_bar, sclk, host_sda, dc;
   logic        ram_wr, cmd_valid, discard, sda_oe, ack, addressed;
   logic [5:0]  ptr_value, ram_addr;
   logic [7:0]  ram_data, cmd_byte;
   logic [13:0] wr_q[$];
   logic [7:0]  cmd_q[$];
   int          mismatches, n_compared, n_discard;
   // Open-drain data line with pull-up
   wire         sda_line = host_sda & ~sda_oe;

   initial begin
      clk_sys_in = 1'h0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end

   lcd_serial_port u_lcd_serial_port (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .clk_en_in(1'h1), .chip_select_bar_in(chip_select_bar), .write_clock_in(sclk), .data_in(sda_line),
      .data_command_select_in(dc), .interface_select_lo_in(if_lo),
      .interface_select_hi_in(if_hi), .data_out(), .data_oe_out(sda_oe),
      .ptr_load_in(ptr_load), .ptr_value_in(ptr_value), .ram_wr_out(ram_wr),
      .ram_addr_out(ram_addr), .ram_data_out(ram_data), .cmd_valid_out(cmd_valid),
      .cmd_byte_out(cmd_byte), .addressed_out(addressed), .discard_out(discard));

   host_link_model u_host_link_model (.clk_sys_in(clk_sys_in), .data_line_in(sda_line),
      .chip_select_bar_out(chip_select_bar), .write_clock_out(sclk), .data_out(host_sda),
      .data_command_select_out(dc));

   // Collect the port's output pulses
   always @(negedge clk_sys_in) begin
      if (ram_wr === 1'h1) wr_q.push_back({ram_addr, ram_data});
      if (cmd_valid === 1'h1) cmd_q.push_back(cmd_byte);
      if (discard === 1'h1) n_discard++;
   end

   task automatic stop_test();
      if (mismatches == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_bits(input string what, input logic [13:0] exp, input logic [13:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_wr(input logic [5:0] a, input logic [7:0] d);
      logic [13:0] got;
      got = 'x;
      if (wr_q.size() > 0) got = wr_q.pop_front();
      chk_bits("ram write", {a, d}, got);
   endtask

   task automatic chk_cmd(input logic [7:0] b);
      logic [7:0] got;
      got = 'x;
      if (cmd_q.size() > 0) got = cmd_q.pop_front();
      chk_bits("command", {6'h00, b}, {6'h00, got});
   endtask

   task automatic i2c_send(input logic [7:0] v, input logic exp_ack);
      u_host_link_model.i2c_byte(v, ack);
      chk_bits("ack", {13'h0000, exp_ack}, {13'h0000, ack});
   endtask

   task automatic set_mode(input logic hi, input logic lo);
      if_hi = hi;
      if_lo = lo;
      repeat (4) @(negedge clk_sys_in);
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_sys_in);
      mismatches++;
      stop_test();
   end

   initial begin
      resetn_in = 1'h0;
      {if_hi, if_lo, ptr_load, ptr_value} = {2'h2, 1'h0, 6'h3F};
      repeat (10) @(negedge clk_sys_in);
      resetn_in = 1'h1;
      set_mode(1'h1, 1'h0);
      ptr_load = 1'h1;
      @(negedge clk_sys_in);
      ptr_load = 1'h0;
      // 4-line: data at top pointer, command, aborted byte, resend wraps pointer
      u_host_link_model.spi_frame(9'h0A5, 8, 1'h1);
      chk_wr(6'h3F, 8'hA5);
      u_host_link_model.spi_frame(9'h03C, 8, 1'h0);
      chk_cmd(8'h3C);
      u_host_link_model.spi_frame(9'h0FF, 5, 1'h1);
      chk_bits("discards", 14'h0001, 14'(n_discard));
      chk_bits("stray writes", 14'h0000, 14'(wr_q.size()));
      u_host_link_model.spi_frame(9'h096, 8, 1'h1);
      chk_wr(6'h00, 8'h96);
      // 3-line: leading flag decides, control pin ignored
      set_mode(1'h0, 1'h1);
      u_host_link_model.spi_frame(9'h15A, 9, 1'h0);
      chk_wr(6'h01, 8'h5A);
      u_host_link_model.spi_frame(9'h0C3, 9, 1'h1);
      chk_cmd(8'hC3);
      // Two-wire: own address, single-byte and streaming control bytes
      set_mode(1'h0, 1'h0);
      u_host_link_model.i2c_start();
      i2c_send(8'h7C, 1'h1);
      chk_bits("addressed", 14'h0001, {13'h0000, addressed});
      i2c_send(8'hC0, 1'h1);
      i2c_send(8'h11, 1'h1);
      chk_wr(6'h02, 8'h11);
      i2c_send(8'h80, 1'h1);
      i2c_send(8'hE3, 1'h1);
      chk_cmd(8'hE3);
      i2c_send(8'h40, 1'h1);
      i2c_send(8'h22, 1'h1);
      i2c_send(8'h33, 1'h1);
      chk_wr(6'h03, 8'h22);
      chk_wr(6'h04, 8'h33);
      u_host_link_model.i2c_stop();
      // Foreign address, then own address with read direction
      u_host_link_model.i2c_start();
      i2c_send(8'h7A, 1'h0);
      chk_bits("addressed", 14'h0000, {13'h0000, addressed});
      i2c_send(8'h40, 1'h0);
      i2c_send(8'h55, 1'h0);
      u_host_link_model.i2c_stop();
      u_host_link_model.i2c_start();
      i2c_send(8'h7D, 1'h0);
      i2c_send(8'hC0, 1'h0);
      u_host_link_model.i2c_stop();
      // Unsupported select code: a full frame must be ignored
      set_mode(1'h1, 1'h1);
      u_host_link_model.spi_frame(9'h0AA, 8, 1'h1);
      chk_bits("stray writes", 14'h0000, 14'(wr_q.size() + cmd_q.size()));
      stop_test();
   end
endmodule // lcd_serial_port_tb_top
